// File: rtl/ta_alarm_defines.svh
// Register offsets, field positions, reset values and timing for the alarm block.
// Assumes the clock runs at 250 MHz.
`ifndef TA_ALARM_DEFINES_SVH
`define TA_ALARM_DEFINES_SVH

`define TA_OFS_CFG        8'h00
`define TA_OFS_ST1        8'h01
`define TA_OFS_ST2        8'h02
`define TA_OFS_MSK1       8'h03
`define TA_OFS_MSK2       8'h04
`define TA_OFS_PINFN      8'h05
`define TA_OFS_OSCFG      8'h06
`define TA_OFS_TEMP       8'h27
`define TA_OFS_LIM_FIRST  8'h38
`define TA_OFS_LIM_LAST   8'h3b

// Configuration register fields
`define TA_CFG_START      0
`define TA_CFG_INT_EN     1
`define TA_CFG_INT_POL    2
`define TA_CFG_HOLDOFF    3
`define TA_CFG_CI_CLR     5

// Status fields
`define TA_ST1_HOT        4
`define TA_ST1_CASCADE    7
`define TA_ST2_BOARD      1
`define TA_ST2_INTRUSION  4
`define TA_ST2_OVERTEMP   5

// Pin function and overtemp config fields
`define TA_PIN_OS_SEL     6
`define TA_PIN_RST_SEL    7
`define TA_OSC_INT_ONCE   1
`define TA_OSC_OS_ONCE    2
`define TA_OSC_RES12      3

// Limit indices from the first limit offset
`define TA_LIM_HOT        0
`define TA_LIM_HOT_HYST   1
`define TA_LIM_OS         2
`define TA_LIM_OS_HYST    3

// Reset values
`define TA_RST_CFG        8'h08
`define TA_RST_MSK        8'h00
`define TA_RST_PINFN      8'h14
`define TA_RST_OSCFG      4'h1
`define TA_RST_LIMIT      8'h7f

// Timing
`define TA_CLK_MHZ        250
`define TA_CI_CLR_MS      10

`endif

// File: rtl/ta_alarm_irq.sv
// Temperature alarm and interrupt aggregation of a hardware monitor.
// Assumes a serial-bus block delivers one-cycle register strobes, and a converter
// delivers a 12-bit result with a one-cycle done pulse, all synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "ta_alarm_defines.svh"

module ta_alarm_irq
  import ta_pkg::*;
#(
  parameter int unsigned CLR_CYCLES = `TA_CI_CLR_MS * 1000 * `TA_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register strobes from the serial-bus block
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic        regWord,
  output logic      [15:0] regRdData,
  // Converter result
  input  wire logic        convDone,
  input  wire logic [11:0] convResult,
  // External interrupt sources
  input  wire logic        intIn_n,
  input  wire logic        boardTempAlert_n,
  input  wire logic        intrusionIn,
  // Intrusion line drive
  output logic             intrusionOut,
  output logic             intrusionOe,
  // Interrupt pin
  output logic             intOut,
  output logic             intOe,
  // Reset/overtemp pin
  output logic             osPinOut,
  output logic             osPinOe
);

  localparam ta_cnt_t CLR_LAST = ta_cnt_t'(CLR_CYCLES - 1);

  ta_state_s st;
  ta_state_s nxt_st;

  logic        [7:0] curT;
  logic              monitoring;
  logic              hotNow;
  logic              hotBelowHyst;
  logic              osNow;
  logic              osBelowHyst;
  logic              osFlagOnce;
  logic              rdSt1;
  logic              rdSt2;
  logic              wrCfg;
  logic              limHit;
  logic        [1:0] limIdx;
  logic              anySrc;
  logic              intAct;
  logic              osPinEn;
  logic              convPend;

  always_comb begin
    nxt_st       = st;
    curT         = st.temp[11:4];
    monitoring   = st.cfg[`TA_CFG_START] & ~st.cfg[`TA_CFG_HOLDOFF];
    hotNow       = $signed(curT) > $signed(st.limit[`TA_LIM_HOT]);
    hotBelowHyst = $signed(curT) < $signed(st.limit[`TA_LIM_HOT_HYST]);
    osNow        = $signed(curT) > $signed(st.limit[`TA_LIM_OS]);
    osBelowHyst  = $signed(curT) < $signed(st.limit[`TA_LIM_OS_HYST]);
    osFlagOnce   = st.osCfg[`TA_OSC_OS_ONCE];
    rdSt1        = regRead & (regAddr == `TA_OFS_ST1);
    rdSt2        = regRead & (regAddr == `TA_OFS_ST2);
    wrCfg        = regWrite & (regAddr == `TA_OFS_CFG);
    limHit       = (regAddr >= `TA_OFS_LIM_FIRST) && (regAddr <= `TA_OFS_LIM_LAST);
    limIdx       = regAddr[1:0];

    // Read side: answer comes one cycle after the strobe
    if (regRead) begin
      nxt_st.rdData = 16'h0000;
      case (regAddr)
        `TA_OFS_CFG:   nxt_st.rdData[7:0] = st.cfg;
        `TA_OFS_ST1:   nxt_st.rdData[7:0] = st.st1;
        `TA_OFS_ST2:   nxt_st.rdData[7:0] = st.st2;
        `TA_OFS_MSK1:  nxt_st.rdData[7:0] = st.msk1;
        `TA_OFS_MSK2:  nxt_st.rdData[7:0] = st.msk2;
        `TA_OFS_PINFN: nxt_st.rdData[7:0] = st.pinFn;
        `TA_OFS_OSCFG: nxt_st.rdData[7:0] = {st.temp[3:0], st.osCfg};
        `TA_OFS_TEMP: begin
          if (regWord) begin
            nxt_st.rdData = {st.temp, 4'h0};
          end else begin
            nxt_st.rdData[7:0] = st.temp[11:4];
          end
        end
        default: begin
          if (limHit) begin
            nxt_st.rdData[7:0] = st.limit[limIdx];
          end
        end
      endcase
    end

    // Reading a status register empties it; sources below win in the same cycle
    if (rdSt1) begin
      nxt_st.st1 = 8'h00;
    end
    if (rdSt2) begin
      nxt_st.st2 = 8'h00;
      if (st.osCfg[`TA_OSC_OS_ONCE]) begin
        nxt_st.osAct = 1'b0;
      end
    end

    // Register writes
    if (regWrite) begin
      case (regAddr)
        `TA_OFS_CFG:   nxt_st.cfg   = regWrData;
        `TA_OFS_MSK1:  nxt_st.msk1  = regWrData;
        `TA_OFS_MSK2:  nxt_st.msk2  = regWrData;
        `TA_OFS_PINFN: nxt_st.pinFn = regWrData;
        `TA_OFS_OSCFG: nxt_st.osCfg = regWrData[3:0];
        default: begin
          if (limHit) begin
            nxt_st.limit[limIdx] = regWrData;
          end
        end
      endcase
    end

    // Intrusion clear pulse: line held low for the full time, then the bit drops
    if (wrCfg && regWrData[`TA_CFG_CI_CLR] && !st.intrusionOe) begin
      nxt_st.intrusionOe = 1'b1;
      nxt_st.clrCnt      = '0;
    end else if (st.intrusionOe) begin
      nxt_st.cfg[`TA_CFG_CI_CLR] = 1'b1;
      if (st.clrCnt == CLR_LAST) begin
        nxt_st.intrusionOe         = 1'b0;
        nxt_st.cfg[`TA_CFG_CI_CLR] = 1'b0;
      end else begin
        nxt_st.clrCnt = st.clrCnt + ta_cnt_t'(1);
      end
    end
    nxt_st.intrusionOut = 1'b0;

    // Conversions are taken only while monitoring runs; hold-off pauses the loop
    if (convDone && monitoring) begin
      if (st.osCfg[`TA_OSC_RES12]) begin
        nxt_st.temp = convResult;
      end else begin
        nxt_st.temp = {convResult[11:3], 3'h0};
      end
    end

    // Limit checks run on the stored result right after it lands
    if (st.cfg[`TA_CFG_START] && !st.cfg[`TA_CFG_HOLDOFF] && convPend) begin
      // Hot flag: default mode re-raises each conversion, one-time waits for hysteresis
      if (!st.osCfg[`TA_OSC_INT_ONCE]) begin
        if (hotNow) begin
          nxt_st.st1[`TA_ST1_HOT] = 1'b1;
        end else if (!rdSt1) begin
          nxt_st.st1[`TA_ST1_HOT] = 1'b0;
        end
      end else begin
        if (hotNow && st.hotArmed) begin
          nxt_st.st1[`TA_ST1_HOT] = 1'b1;
          nxt_st.hotArmed         = 1'b0;
        end else if (hotBelowHyst) begin
          nxt_st.hotArmed = 1'b1;
        end
      end
      // Overtemp status flag follows the same two modes
      if (!osFlagOnce) begin
        if (osNow) begin
          nxt_st.st2[`TA_ST2_OVERTEMP] = 1'b1;
        end else if (!rdSt2) begin
          nxt_st.st2[`TA_ST2_OVERTEMP] = 1'b0;
        end
      end else begin
        if (osNow && st.osArmed) begin
          nxt_st.st2[`TA_ST2_OVERTEMP] = 1'b1;
          nxt_st.osArmed               = 1'b0;
          nxt_st.osAct                 = 1'b1;
        end else if (osBelowHyst) begin
          nxt_st.osArmed = 1'b1;
        end
      end
      // Comparator pin mode holds between the limit and its hysteresis
      if (!osFlagOnce) begin
        if (osNow) begin
          nxt_st.osAct = 1'b1;
        end else if (osBelowHyst) begin
          nxt_st.osAct = 1'b0;
        end
      end
    end

    // External sources are level-sensed every cycle
    if (!intIn_n) begin
      nxt_st.st1[`TA_ST1_CASCADE] = 1'b1;
    end
    if (!boardTempAlert_n) begin
      nxt_st.st2[`TA_ST2_BOARD] = 1'b1;
    end
    if (intrusionIn) begin
      nxt_st.st2[`TA_ST2_INTRUSION] = 1'b1;
    end

    // Interrupt pin; a status read drops it at once, even if a source sets again
    anySrc = |(nxt_st.st1 & ~nxt_st.msk1) | |(nxt_st.st2 & ~nxt_st.msk2);
    intAct = anySrc & nxt_st.cfg[`TA_CFG_INT_EN]
             & ~nxt_st.cfg[`TA_CFG_HOLDOFF] & ~(rdSt1 | rdSt2);
    nxt_st.intOut = nxt_st.cfg[`TA_CFG_INT_POL];
    nxt_st.intOe  = intAct;

    // Shared pin carries the active-low overtemp signal only in its overtemp role
    osPinEn = nxt_st.pinFn[`TA_PIN_OS_SEL] & ~nxt_st.pinFn[`TA_PIN_RST_SEL];
    nxt_st.osPinOut = 1'b0;
    nxt_st.osPinOe  = osPinEn & nxt_st.osAct;
  end

  // A conversion is evaluated the cycle after it is stored
  always_ff @(posedge clk) begin
    if (rst) begin
      convPend <= 1'b0;
    end else begin
      convPend <= convDone & monitoring;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st          <= '0;
      st.cfg      <= `TA_RST_CFG;
      st.msk1     <= `TA_RST_MSK;
      st.msk2     <= `TA_RST_MSK;
      st.pinFn    <= `TA_RST_PINFN;
      st.osCfg    <= `TA_RST_OSCFG;
      st.limit    <= {4{`TA_RST_LIMIT}};
      st.hotArmed <= 1'b1;
      st.osArmed  <= 1'b1;
    end else begin
      st <= nxt_st;
    end
  end

  assign regRdData    = st.rdData;
  assign intOut       = st.intOut;
  assign intOe        = st.intOe;
  assign osPinOut     = st.osPinOut;
  assign osPinOe      = st.osPinOe;
  assign intrusionOut = st.intrusionOut;
  assign intrusionOe  = st.intrusionOe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_holdoff_quiet;
    st.cfg[`TA_CFG_HOLDOFF] |-> !intOe;
  endproperty
  a_holdoff_quiet: assert property (p_holdoff_quiet)
    else $error("interrupt driven during hold-off");

  property p_int_enable;
    !st.cfg[`TA_CFG_INT_EN] |-> !intOe;
  endproperty
  a_int_enable: assert property (p_int_enable)
    else $error("interrupt driven while disabled");

  property p_read_clear;
    (regRead && regAddr == `TA_OFS_ST1 && intIn_n && !convPend)
      |=> (st.st1 == 8'h00) && !intOe;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status one not cleared by read");

  property p_cascade;
    !intIn_n |=> st.st1[`TA_ST1_CASCADE];
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascaded input not captured");

  property p_board;
    !boardTempAlert_n |=> st.st2[`TA_ST2_BOARD];
  endproperty
  a_board: assert property (p_board)
    else $error("board alert not captured");

  property p_intrusion;
    intrusionIn |=> st.st2[`TA_ST2_INTRUSION];
  endproperty
  a_intrusion: assert property (p_intrusion)
    else $error("intrusion not captured");

  sequence s_clr_start;
    regWrite && regAddr == `TA_OFS_CFG && regWrData[`TA_CFG_CI_CLR] && !intrusionOe;
  endsequence
  property p_clr_hold;
    s_clr_start |=> (intrusionOe && !intrusionOut) [*8];
  endproperty
  a_clr_hold: assert property (p_clr_hold)
    else $error("intrusion clear pulse too short");

  property p_temp_byte;
    (regRead && regAddr == `TA_OFS_TEMP && !regWord)
      |=> regRdData == {8'h00, $past(st.temp[11:4])};
  endproperty
  a_temp_byte: assert property (p_temp_byte)
    else $error("temperature byte read wrong");

  property p_default_hot;
    (convPend && monitoring && !st.osCfg[`TA_OSC_INT_ONCE] && hotNow)
      |=> st.st1[`TA_ST1_HOT];
  endproperty
  a_default_hot: assert property (p_default_hot)
    else $error("hot flag not raised in default mode");

  property p_os_pin_role;
    osPinOe |-> st.pinFn[`TA_PIN_OS_SEL] && !st.pinFn[`TA_PIN_RST_SEL] && !osPinOut;
  endproperty
  a_os_pin_role: assert property (p_os_pin_role)
    else $error("overtemp pin driven outside its role");

  property p_int_source;
    (!intIn_n && !st.msk1[`TA_ST1_CASCADE] && st.cfg[`TA_CFG_INT_EN]
      && !st.cfg[`TA_CFG_HOLDOFF] && !regWrite && !regRead)
      |=> intOe;
  endproperty
  a_int_source: assert property (p_int_source)
    else $error("unmasked source did not drive interrupt");

  property p_hot_once;
    (convPend && monitoring && st.osCfg[`TA_OSC_INT_ONCE] && !st.hotArmed)
      |=> !$rose(st.st1[`TA_ST1_HOT]);
  endproperty
  a_hot_once: assert property (p_hot_once)
    else $error("hot flag raised again before rearm");

  property p_comp_release;
    (convPend && monitoring && !osFlagOnce && !osNow && osBelowHyst)
      |=> !osPinOe;
  endproperty
  a_comp_release: assert property (p_comp_release)
    else $error("overtemp pin held below hysteresis");

  property p_os_once_clear;
    (rdSt2 && osFlagOnce && !(convPend && monitoring && osNow && st.osArmed))
      |=> !osPinOe;
  endproperty
  a_os_once_clear: assert property (p_os_once_clear)
    else $error("one-time overtemp pin not released by read");

  property p_res9;
    (convDone && monitoring && !st.osCfg[`TA_OSC_RES12])
      |=> st.temp[2:0] == 3'h0;
  endproperty
  a_res9: assert property (p_res9)
    else $error("low bits kept in 9-bit mode");

  property p_word_read;
    (regRead && regAddr == `TA_OFS_TEMP && regWord)
      |=> regRdData == {$past(st.temp), 4'h0};
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("temperature word read wrong");

endmodule // ta_alarm_irq
`default_nettype wire

// File: rtl/ta_pkg.sv
// Types shared by the temperature alarm and interrupt logic.
// Assumes nothing beyond the defines header.
package ta_pkg;

  typedef logic [7:0] ta_byte_t;
  typedef logic [23:0] ta_cnt_t;

  typedef struct packed {
    ta_byte_t            cfg;
    ta_byte_t            st1;
    ta_byte_t            st2;
    ta_byte_t            msk1;
    ta_byte_t            msk2;
    ta_byte_t            pinFn;
    logic [3:0]          osCfg;
    logic [11:0]         temp;
    logic [3:0][7:0]     limit;
    logic                hotArmed;
    logic                osArmed;
    logic                osAct;
    ta_cnt_t             clrCnt;
    logic [15:0]         rdData;
    logic                intOut;
    logic                intOe;
    logic                osPinOut;
    logic                osPinOe;
    logic                intrusionOut;
    logic                intrusionOe;
  } ta_state_s;

endpackage

// File: tb/ta_alarm_irq_test.sv
// Self-checking bench for the temperature alarm and interrupt block.
// Assumes one 250 MHz clock; the intrusion clear pulse is shortened to 16 cycles.
`timescale 1ns/100ps
`default_nettype none

module ta_alarm_irq_test;
  logic        clk = 0, rst = 1;
  logic [7:0]  regAddr = 0, regWrData = 0;
  logic        regWrite = 0, regRead = 0, regWord = 0, convDone = 0;
  logic [11:0] convResult = 0;
  logic [2:0]  srcOn = 0;
  logic        intPullHigh = 1;
  logic [15:0] regRdData, d;
  logic        intrusionOut, intrusionOe, intOut, intOe, osPinOut, osPinOe;
  logic        intLine, osLine;
  int          errors = 0, samples_checked = 0, n;
  logic [7:0]  rstAddr [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h38,
                                8'h3b, 8'h10};
  logic [7:0]  rstVal [10] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h7f,
                               8'h7f, 8'h00};
  logic [7:0]  srcBit [3] = '{8'h80, 8'h02, 8'h10};

  always #2 clk = ~clk;

  ta_alarm_irq #(.CLR_CYCLES(16)) i_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regWord(regWord), .regRdData(regRdData), .convDone(convDone),
    .convResult(convResult), .intIn_n(~srcOn[0]), .boardTempAlert_n(~srcOn[1]),
    // The device pulls the intrusion line low over the external latch
    .intrusionIn(srcOn[2] & ~intrusionOe), .intrusionOut(intrusionOut),
    .intrusionOe(intrusionOe), .intOut(intOut), .intOe(intOe), .osPinOut(osPinOut),
    .osPinOe(osPinOe));

  ta_host_model i_host (
    .intOut(intOut), .intOe(intOe), .osPinOut(osPinOut), .osPinOe(osPinOe),
    .intPullHigh(intPullHigh), .intLine(intLine), .osLine(osLine));

  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regAddr = a;
    regWrData = v;
    regWrite = 1;
    @(negedge clk);
    regWrite = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic w);
    @(negedge clk);
    regAddr = a;
    regWord = w;
    regRead = 1;
    @(negedge clk);
    regRead = 0;
    regWord = 0;
    d = regRdData;
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    rd(a, 0);
    chk($sformatf("reg %h", a), d, {8'h00, e});
  endtask

  // Waits until the limit checks of the conversion have landed
  task automatic conv(input logic [11:0] v);
    @(negedge clk);
    convDone = 1;
    convResult = v;
    @(negedge clk);
    convDone = 0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 10; i++) chkrd(rstAddr[i], rstVal[i]);
    wr(8'h00, 8'h03);
    wr(8'h38, 8'h19);
    wr(8'h39, 8'h14);
    wr(8'h06, 8'hf9);
    conv(12'h1a5);
    chk("intLine hot", intLine, 0);
    chkrd(8'h27, 8'h1a);
    chkrd(8'h06, 8'h59);
    rd(8'h27, 1);
    chk("word temp", d, 16'h1a50);
    chkrd(8'h01, 8'h10);
    chk("intLine cleared", intLine, 1);
    conv(12'h1a5);
    chk("intLine again", intLine, 0);
    conv(12'h180);
    chk("intLine cool", intLine, 1);
    chkrd(8'h01, 8'h00);
    wr(8'h06, 8'h0b);
    conv(12'h1a5);
    chkrd(8'h01, 8'h10);
    conv(12'h1a5);
    chkrd(8'h01, 8'h00);
    conv(12'h100);
    conv(12'h1a5);
    chkrd(8'h01, 8'h10);
    conv(12'h100);
    for (int i = 0; i < 3; i++) begin
      srcOn[i] = 1;
      repeat (3) @(negedge clk);
      chk($sformatf("intLine src %0d", i), intLine, 0);
      srcOn[i] = 0;
      chkrd((i == 0) ? 8'h01 : 8'h02, srcBit[i]);
      wr((i == 0) ? 8'h03 : 8'h04, srcBit[i]);
      srcOn[i] = 1;
      repeat (3) @(negedge clk);
      chk($sformatf("masked src %0d", i), intLine, 1);
      srcOn[i] = 0;
      rd((i == 0) ? 8'h01 : 8'h02, 0);
      wr((i == 0) ? 8'h03 : 8'h04, 8'h00);
    end
    srcOn[0] = 1;
    repeat (3) @(negedge clk);
    wr(8'h00, 8'h0b);
    repeat (2) @(negedge clk);
    chk("intLine holdoff", intLine, 1);
    srcOn[0] = 0;
    conv(12'h1a5);
    chkrd(8'h27, 8'h10);
    chkrd(8'h01, 8'h80);
    wr(8'h00, 8'h03);
    wr(8'h05, 8'h54);
    wr(8'h3a, 8'h1e);
    wr(8'h3b, 8'h1c);
    wr(8'h06, 8'h09);
    conv(12'h1f0);
    chk("osLine hot", osLine, 0);
    chkrd(8'h02, 8'h20);
    conv(12'h1d0);
    chk("osLine hyst", osLine, 0);
    conv(12'h1b0);
    chk("osLine cool", osLine, 1);
    wr(8'h06, 8'h0d);
    conv(12'h1f0);
    chk("osLine once", osLine, 0);
    chkrd(8'h02, 8'h20);
    chk("osLine read", osLine, 1);
    conv(12'h1f0);
    chk("osLine no rearm", osLine, 1);
    conv(12'h1b0);
    wr(8'h05, 8'hd4);
    conv(12'h1f0);
    chk("osLine role off", osLine, 1);
    chkrd(8'h02, 8'h20);
    wr(8'h06, 8'h05);
    conv(12'h1ad);
    rd(8'h27, 1);
    chk("word temp 9-bit", d, 16'h1a80);
    chkrd(8'h06, 8'h85);
    rd(8'h01, 0);
    wr(8'h00, 8'h23);
    n = 0;
    while (intrusionOe !== 1'b1 && n < 5) begin
      n++;
      @(negedge clk);
    end
    n = 0;
    while (intrusionOe === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk("clear pulse", 16'(n), 16'd16);
    chk("intrusion drive", intrusionOut, 0);
    chkrd(8'h00, 8'h03);
    intPullHigh = 0;
    wr(8'h00, 8'h07);
    srcOn[0] = 1;
    repeat (3) @(negedge clk);
    chk("active high int", intLine, 1);
    wr(8'h00, 8'h05);
    repeat (2) @(negedge clk);
    chk("int disabled", intLine, 0);
    srcOn[0] = 0;
    report_and_stop();
  end
endmodule // ta_alarm_irq_test

`default_nettype wire

// File: tb/ta_host_model.sv
// Host side of the alarm block: resolves the interrupt and overtemp wires.
// Assumes board pull resistors set the idle level of each open line.
`timescale 1ns/100ps
`default_nettype none

module ta_host_model (
  // Device pin drive
  input  wire logic intOut,
  input  wire logic intOe,
  input  wire logic osPinOut,
  input  wire logic osPinOe,
  // Board pull level of the interrupt line
  input  wire logic intPullHigh,
  // Levels seen by the host
  output logic      intLine,
  output logic      osLine
);
  // Undriven lines rest at the pull level, never at the last driven value
  assign intLine = intOe ? intOut : intPullHigh;
  assign osLine  = osPinOe ? osPinOut : 1'b1;
endmodule // ta_host_model

`default_nettype wire
